// ===== hw/lcd_command_decoder.v
// host command decoder, control register bank and display ram pointers
//
// Function
// RL1: data writes and reads use display ram at the bank and column pointers
// RL2: after each data access the pointers step as address control says
// RL3: wrap off: column pointer halts at last column
// RL4: wrap on: last column clears column, bank pointer steps one
// RL5: bank pointer passing a ram end wraps to the other end
// RL6: status read: busy, column flip, display on, reset pending, four zeros
// RL7: display-on status equals the display enable control bit
// RL8: host stays off the bus while reset pending; busy alone is fine
// RL9: two commands load column pointer low and high nibble; reset zero
// RL10: gain command loads three-bit coarse gain, reset 011b
// RL11: pump command loads three-bit pump setting, reset 111b
// RL12: start line command loads six-bit scroll offset
// RL13: display control bits invert, all on, display on; reset off
// RL14: address control bit 2 picks bank step sign plus or minus
// RL15: cursor hold: column steps on writes only, no column wrap
// RL16: mapping bits swap, reserved, column flip, row flip; reset zero
// RL17: host writes zero to reserved address and mapping bit 1
// RL18: host sends only listed command encodings
// RL19: operating state reads 10b sleep, 11b normal, 00b reset
// RL20: host avoids vendor config command; its byte resets to 6ch
// RL21: bias ratio resets from pins, command may overwrite
// RL22: temperature coefficient comes from pins
// RL23: bank pointer command loads four-bit bank number
// RL24: software reset holds reset pending about 5 ms
// RL25: cursor hold entry saves column; exit restores it
// RL26: bytes received while reset pending are ignored
`timescale 1ns/10ps
`include "lcd_map.vh"
module lcd_command_decoder #(
    parameter RESET_CYCLES = `LCD_SWRST_CYCLES
)(
    input wire mclk, // core clock, 250 mhz
    input wire srst, // synchronous reset, active high
    input wire host_strobe, // one-cycle host access request
    input wire host_data_sel, // 1 data phase, 0 control phase
    input wire host_read, // 1 read cycle, 0 write cycle
    input wire [7:0] host_wdata, // write byte from host
    input wire [1:0] bias_ratio_pins, // bias ratio straps
    input wire [1:0] temp_coeff_pins, // temperature coefficient straps
    input wire [1:0] multiplex_pins, // multiplex rate straps
    output reg [7:0] host_rdata, // read byte to host
    output reg host_rvalid, // read byte valid, one cycle
    output reg [4:0] row_bank_pointer, // current bank pointer
    output reg [7:0] column_pointer, // current column pointer
    output reg [2:0] coarse_gain, // gain code
    output reg [5:0] fine_trim, // potentiometer trim
    output reg [2:0] pump_setting, // pump control
    output reg [5:0] scroll_offset, // start line
    output reg [2:0] display_control_bits, // invert, all on, display on
    output reg [3:0] address_control_bits, // wrap, reserved, sign, cursor hold
    output reg [3:0] panel_map_bits, // swap, reserved, column flip, row flip
    output reg [7:0] vendor_config_byte, // factory byte
    output reg [1:0] bias_ratio_select, // bias ratio
    output reg [1:0] temp_coeff_select, // temperature coefficient
    output reg [1:0] multiplex_select, // multiplex rate
    output reg [1:0] operating_state, // state code
    output reg busy_flag, // internal process running
    output reg reset_pending // system reset in progress
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function [7:0] swap_bits;
        input [7:0] b;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1)
                swap_bits[i] = b[7 - i];
        end
    endfunction

    function match;
        input [7:0] b;
        input [7:0] mask;
        input [7:0] val;
        begin
            match = ((b & mask) == val);
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_TRIM = 2'h1;
    localparam ST_VENDOR = 2'h2;
    localparam ST_TEST = 2'h3;

    reg [1:0] state;
    reg [7:0] cursor_save;
    reg straps_taken;
    reg read_pend;
    reg read_swap;
    reg timer_start;
    wire timer_pending;
    wire [7:0] ram_rdata;
    wire [7:0] effective_col;
    wire [12:0] ram_addr;
    wire wrap_enable;
    wire bank_step_sign;
    wire cursor_hold_mode;
    wire display_on_flag;
    wire column_flip;
    wire accept;
    wire data_wr;
    wire data_rd;
    wire ctl_wr;
    wire ctl_rd;
    reg [7:0] next_col;
    reg [4:0] next_bank;

    assign wrap_enable = address_control_bits[`LCD_AC_WRAP];
    assign bank_step_sign = address_control_bits[`LCD_AC_SIGN];
    assign cursor_hold_mode = address_control_bits[`LCD_AC_CURSOR];
    assign display_on_flag = display_control_bits[`LCD_DC_ON];
    assign column_flip = panel_map_bits[`LCD_LC_CFLIP];
    // start and the status copy close the cycles just before and after the timer window
    assign accept = host_strobe && !timer_pending && !timer_start && !reset_pending; // [RL26]
    assign data_wr = accept && host_data_sel && !host_read;
    assign data_rd = accept && host_data_sel && host_read;
    assign ctl_wr = accept && !host_data_sel && !host_read;
    assign ctl_rd = accept && !host_data_sel && host_read;

    // column flip applies at access time only
    assign effective_col = column_flip ? (`LCD_LAST_COLUMN - column_pointer) : column_pointer;
    assign ram_addr = row_bank_pointer * 13'd132 + {5'h0, effective_col}; // [RL1]

    lcd_display_ram u_ram (
        .mclk(mclk),
        .wr_en(data_wr),
        .addr(ram_addr),
        .wr_data(panel_map_bits[`LCD_LC_SWAP] ? swap_bits(host_wdata) : host_wdata),
        .rd_data(ram_rdata)
    ); // [RL1]

    lcd_reset_timer #(
        .RESET_CYCLES(RESET_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .srst(srst),
        .start(timer_start),
        .pending(timer_pending)
    ); // [RL24]

    // ----------------------------------------
    // pointer stepping after a data access
    // ----------------------------------------
    always @*
    begin
        next_col = column_pointer;
        next_bank = row_bank_pointer;
        if ((data_wr || (data_rd && !cursor_hold_mode))) // [RL2] [RL15]
        begin
            if (column_pointer < `LCD_LAST_COLUMN)
                next_col = column_pointer + 8'h1;
            else if (wrap_enable && !cursor_hold_mode) // [RL3] [RL15]
            begin
                next_col = 8'h0; // [RL4]
                if (!bank_step_sign) // [RL14]
                    next_bank = (row_bank_pointer == `LCD_LAST_BANK) ? 5'h0
                        : row_bank_pointer + 5'h1; // [RL5]
                else
                    next_bank = (row_bank_pointer == 5'h0) ? `LCD_LAST_BANK
                        : row_bank_pointer - 5'h1; // [RL5]
            end
        end
    end

    // ----------------------------------------
    // command decode and registers
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (srst || timer_pending)
        begin
            // held at reset values for the whole software reset window
            state <= ST_IDLE;
            column_pointer <= 8'h0; // [RL9]
            row_bank_pointer <= 5'h0;
            cursor_save <= 8'h0;
            coarse_gain <= `LCD_RST_GAIN; // [RL10]
            fine_trim <= `LCD_RST_TRIM;
            pump_setting <= `LCD_RST_PUMP; // [RL11]
            scroll_offset <= `LCD_RST_SCROLL;
            display_control_bits <= `LCD_RST_DISP; // [RL13]
            address_control_bits <= `LCD_RST_ADDR;
            panel_map_bits <= `LCD_RST_MAP; // [RL16]
            vendor_config_byte <= `LCD_RST_VENDOR;
            timer_start <= 1'b0;
            read_pend <= 1'b0;
            read_swap <= 1'b0;
            straps_taken <= 1'b0;
            bias_ratio_select <= 2'h0;
        end
        else
        begin
            timer_start <= 1'b0;
            read_pend <= data_rd;
            read_swap <= panel_map_bits[`LCD_LC_SWAP];
            // bias ratio straps caught on the first clock after either reset
            if (!straps_taken)
            begin
                straps_taken <= 1'b1;
                bias_ratio_select <= bias_ratio_pins; // [RL21]
            end
            column_pointer <= next_col;
            row_bank_pointer <= next_bank;
            if (ctl_wr)
            begin
                case (state)
                    ST_TRIM:
                    begin
                        fine_trim <= host_wdata[5:0];
                        state <= ST_IDLE;
                    end
                    ST_VENDOR:
                    begin
                        vendor_config_byte <= host_wdata;
                        state <= ST_IDLE;
                    end
                    ST_TEST:
                        state <= ST_IDLE;
                    default:
                    begin
                        if (match(host_wdata, 8'hf0, 8'h00))
                            column_pointer <= {column_pointer[7:4], host_wdata[3:0]}; // [RL9]
                        else if (match(host_wdata, 8'hf0, 8'h10))
                            column_pointer <= {host_wdata[3:0], column_pointer[3:0]}; // [RL9]
                        else if (match(host_wdata, 8'hf8, 8'h20))
                            coarse_gain <= host_wdata[2:0]; // [RL10]
                        else if (match(host_wdata, 8'hf8, 8'h28))
                            pump_setting <= host_wdata[2:0]; // [RL11]
                        else if (match(host_wdata, 8'hfe, 8'h30))
                            state <= ST_VENDOR; // [RL20]
                        else if (match(host_wdata, 8'hc0, 8'h40))
                            scroll_offset <= host_wdata[5:0]; // [RL12]
                        else if (match(host_wdata, 8'hf0, 8'hb0))
                            row_bank_pointer <= {1'b0, host_wdata[3:0]}; // [RL23]
                        else if (host_wdata == 8'h81)
                            state <= ST_TRIM;
                        else if (match(host_wdata, 8'hf8, 8'h88))
                            address_control_bits[2:0] <= host_wdata[2:0];
                        else if (match(host_wdata, 8'hfe, 8'ha0))
                            panel_map_bits[`LCD_LC_RFLIP] <= host_wdata[0];
                        else if (match(host_wdata, 8'hfe, 8'ha4))
                            display_control_bits[`LCD_DC_ALL] <= host_wdata[0]; // [RL13]
                        else if (match(host_wdata, 8'hfe, 8'ha6))
                            display_control_bits[`LCD_DC_INV] <= host_wdata[0]; // [RL13]
                        else if (match(host_wdata, 8'hfe, 8'hae))
                            display_control_bits[`LCD_DC_ON] <= host_wdata[0]; // [RL13]
                        else if (match(host_wdata, 8'hf0, 8'hc0))
                            panel_map_bits <= host_wdata[3:0]; // [RL16]
                        else if (host_wdata == 8'he2)
                            timer_start <= 1'b1; // [RL24]
                        else if (match(host_wdata, 8'hfc, 8'he8))
                            bias_ratio_select <= host_wdata[1:0]; // [RL21]
                        else if (host_wdata == 8'hee)
                        begin
                            address_control_bits[`LCD_AC_CURSOR] <= 1'b0; // [RL25]
                            column_pointer <= cursor_save; // [RL25]
                        end
                        else if (host_wdata == 8'hef)
                        begin
                            address_control_bits[`LCD_AC_CURSOR] <= 1'b1; // [RL25]
                            cursor_save <= column_pointer; // [RL25]
                        end
                        else if (match(host_wdata, 8'hfc, 8'he4))
                            state <= ST_TEST;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // status, read data and strapped values
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (srst)
        begin
            host_rdata <= 8'h00;
            host_rvalid <= 1'b0;
            reset_pending <= 1'b0;
            busy_flag <= 1'b0;
            operating_state <= `LCD_OPS_RESET;
            temp_coeff_select <= 2'h0;
            multiplex_select <= 2'h0;
        end
        else
        begin
            reset_pending <= timer_pending || timer_start;
            busy_flag <= timer_pending || timer_start;
            temp_coeff_select <= temp_coeff_pins; // [RL22]
            multiplex_select <= multiplex_pins;
            operating_state <= timer_pending ? `LCD_OPS_RESET
                : (display_on_flag ? `LCD_OPS_NORMAL : `LCD_OPS_SLEEP); // [RL19]
            host_rvalid <= ctl_rd || read_pend;
            if (ctl_rd)
                host_rdata <= {busy_flag, column_flip, display_on_flag, reset_pending,
                    4'h0}; // [RL6] [RL7]
            else if (read_pend)
                host_rdata <= read_swap ? swap_bits(ram_rdata) : ram_rdata; // [RL1]
        end
    end
endmodule // lcd_command_decoder

// ===== hw/lcd_map.vh
// reset values, field positions, address limits, state codes and timing counts for the lcd command decoder
`ifndef LCD_MAP_VH
`define LCD_MAP_VH

// ----------------------------------------
// reset values
// ----------------------------------------
`define LCD_RST_GAIN 3'h3
`define LCD_RST_TRIM 6'h10
`define LCD_RST_PUMP 3'h7
`define LCD_RST_VENDOR 8'h6c
`define LCD_RST_DISP 3'h0
`define LCD_RST_ADDR 4'h0
`define LCD_RST_MAP 4'h0
`define LCD_RST_SCROLL 6'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define LCD_AC_WRAP 0
`define LCD_AC_SIGN 2
`define LCD_AC_CURSOR 3
`define LCD_DC_INV 0
`define LCD_DC_ALL 1
`define LCD_DC_ON 2
`define LCD_LC_SWAP 0
`define LCD_LC_CFLIP 2
`define LCD_LC_RFLIP 3

// ----------------------------------------
// address space
// ----------------------------------------
`define LCD_LAST_COLUMN 8'h83
`define LCD_LAST_BANK 5'h1f
`define LCD_RAM_DEPTH 4224

// ----------------------------------------
// operating state codes
// ----------------------------------------
`define LCD_OPS_SLEEP 2'h2
`define LCD_OPS_NORMAL 2'h3
`define LCD_OPS_RESET 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define LCD_SWRST_US 5000
`define LCD_CLK_MHZ 250
`define LCD_SWRST_CYCLES (`LCD_SWRST_US * `LCD_CLK_MHZ)

`endif

// ===== hw/lcd_reset_timer.v
// software reset timer holding reset_pending for the documented time
`timescale 1ns/10ps
`include "lcd_map.vh"
module lcd_reset_timer #(
    parameter RESET_CYCLES = `LCD_SWRST_CYCLES
)(
    input wire mclk, // core clock
    input wire srst, // synchronous reset, active high
    input wire start, // one-cycle request to start a system reset
    output reg pending // high while the reset runs
);
    reg [31:0] count;

    always @(posedge mclk)
    begin
        if (srst)
        begin
            pending <= 1'b0;
            count <= 32'h0;
        end
        else if (start && !pending)
        begin
            pending <= 1'b1;
            count <= RESET_CYCLES - 1;
        end
        else if (pending)
        begin
            if (count == 32'h0)
                pending <= 1'b0;
            else
                count <= count - 32'h1;
        end
    end
endmodule // lcd_reset_timer

// ===== hw/lcd_display_ram.v
// display ram: one byte per column per bank, one read or write per cycle
`timescale 1ns/10ps
`include "lcd_map.vh"
module lcd_display_ram (
    input wire mclk, // core clock
    input wire wr_en, // write strobe
    input wire [12:0] addr, // bank*132 + column
    input wire [7:0] wr_data, // write byte
    output reg [7:0] rd_data // read byte, one cycle after addr
);
    reg [7:0] mem [0:`LCD_RAM_DEPTH-1];

    always @(posedge mclk)
    begin
        if (wr_en)
            mem[addr] <= wr_data;
        rd_data <= mem[addr];
    end
endmodule // lcd_display_ram

// ===== tb/lcd_chk.sv
// assertion checker for the lcd command decoder
`timescale 1ns/10ps
module lcd_chk #(
    parameter RESET_CYCLES = 20
)(
    input logic mclk, // clock
    input logic srst, // reset
    input logic host_strobe, // request
    input logic host_data_sel, // data phase
    input logic host_read, // read
    input logic [7:0] host_wdata, // write byte
    input logic [7:0] host_rdata, // read byte
    input logic host_rvalid, // read valid
    input logic [4:0] row_bank_pointer, // bank
    input logic [7:0] column_pointer, // column
    input logic [2:0] coarse_gain, // gain
    input logic [2:0] pump_setting, // pump
    input logic [5:0] scroll_offset, // scroll
    input logic [2:0] display_control_bits, // display
    input logic [3:0] address_control_bits, // address
    input logic [3:0] panel_map_bits, // mapping
    input logic [1:0] operating_state, // state
    input logic busy_flag, // busy
    input logic reset_pending // reset running
);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
// ----------------------------------------
// helpers
// ----------------------------------------
logic [1:0] sr_age;
logic prm;
// accesses just after the reset command are dropped before reset_pending shows
wire take = host_strobe && !reset_pending && !busy_flag && sr_age == 2'h0;
wire cmd = take && !host_data_sel && !host_read;
wire op = cmd && !prm;
wire stat = take && !host_data_sel && host_read;
wire dwr = take && host_data_sel && !host_read;
wire drd = take && host_data_sel && host_read;
wire [3:0] ac = address_control_bits;
wire sgn = ac[2];
wire mx = panel_map_bits[2];
wire de = display_control_bits[2];
always @(posedge mclk)
begin
    if (srst)
    begin
        sr_age <= 2'h0;
        prm <= 1'b0;
    end
    else
    begin
        sr_age <= {sr_age[0], op && host_wdata == 8'he2};
        if (cmd)
            prm <= !prm && (host_wdata[7:1] == 7'h18 || host_wdata == 8'h81
                || host_wdata[7:2] == 6'h39);
    end
end
// ----------------------------------------
// assertions
// ----------------------------------------
status_read_a: assert property (stat |=> host_rvalid && host_rdata ==
    {$past(busy_flag), $past(mx), $past(de), $past(reset_pending), 4'h0})
    else $error("status byte wrong");
read_latency_a: assert property (drd |-> ##2 host_rvalid)
    else $error("data read late");
reset_state_a: assert property ($rose(reset_pending) |=>
    (operating_state == 2'h0 && busy_flag && reset_pending) [*8]) else $error("reset short");
gain_load_a: assert property (op && host_wdata[7:3] == 5'h04 |=>
    $past(host_wdata) == {5'h04, coarse_gain}) else $error("gain not loaded");
pump_load_a: assert property (op && host_wdata[7:3] == 5'h05 |=>
    $past(host_wdata) == {5'h05, pump_setting}) else $error("pump not loaded");
scroll_load_a: assert property (op && host_wdata[7:6] == 2'h1 |=>
    $past(host_wdata) == {2'h1, scroll_offset}) else $error("scroll not loaded");
bank_load_a: assert property (op && host_wdata[7:4] == 4'hb |=> !row_bank_pointer[4] &&
    $past(host_wdata) == {4'hb, row_bank_pointer[3:0]}) else $error("bank not loaded");
column_step_a: assert property ((dwr || drd && !ac[3]) && column_pointer < 8'h83 |=>
    column_pointer == $past(column_pointer) + 8'h01) else $error("column not stepped");
column_halt_a: assert property (dwr && column_pointer == 8'h83 && (!ac[0] || ac[3])
    |=> column_pointer == 8'h83) else $error("column moved past end");
wrap_step_a: assert property (dwr && column_pointer == 8'h83 && ac[0] && !ac[3] |=>
    column_pointer == 8'h00 &&
    row_bank_pointer == $past(row_bank_pointer) + ($past(sgn) ? 5'h1f : 5'h01))
    else $error("wrap step wrong");
busy_ignore_a: assert property (host_strobe && reset_pending |=>
    $stable(coarse_gain) && $stable(column_pointer)) else $error("access taken in reset");
endmodule // lcd_chk

bind lcd_command_decoder lcd_chk #(.RESET_CYCLES(RESET_CYCLES)) i_lcd_chk (.mclk, .srst,
    .host_strobe, .host_data_sel, .host_read, .host_wdata, .host_rdata, .host_rvalid,
    .row_bank_pointer, .column_pointer, .coarse_gain, .pump_setting, .scroll_offset,
    .display_control_bits, .address_control_bits, .panel_map_bits, .operating_state,
    .busy_flag, .reset_pending);

// ===== tb/lcd_host_bfm.sv
// host model issuing byte accesses to the lcd command decoder
`timescale 1ns/10ps
module lcd_host_bfm (
    input logic mclk, // clock
    input logic [7:0] host_rdata, // read byte
    input logic host_rvalid, // read valid
    input logic reset_pending, // reset running
    output logic host_strobe, // request
    output logic host_data_sel, // data phase
    output logic host_read, // read
    output logic [7:0] host_wdata, // write byte
    output logic timed_out // a read wait ran out
);
initial
begin
    host_strobe = 1'b0;
    host_data_sel = 1'b0;
    host_read = 1'b0;
    host_wdata = 8'h00;
    timed_out = 1'b0;
end
// callers pass only listed encodings, reserved bits zero, never the vendor command
// rude skips the reset wait on purpose
task automatic xfer(input logic ds, input logic rd, input logic [7:0] wd, input logic rude,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    while (reset_pending && !rude && n < 100)
    begin
        @(posedge mclk);
        n++;
    end
    host_strobe <= 1'b1;
    host_data_sel <= ds;
    host_read <= rd;
    host_wdata <= wd;
    @(posedge mclk);
    host_strobe <= 1'b0;
    // idle bus shows a changed byte, not the last one
    host_wdata <= ~wd;
    n = 0;
    #1;
    while (rd && host_rvalid !== 1'b1 && n < 4)
    begin
        @(posedge mclk);
        #1;
        n++;
    end
    if (rd && host_rvalid !== 1'b1)
        timed_out = 1'b1;
    q = host_rdata;
endtask
endmodule // lcd_host_bfm

// ===== tb/tb_top.sv
// self-checking bench for the lcd command decoder
`timescale 1ns/10ps
module tb_top;
logic mclk = 1'b0;
logic srst = 1'b1;
logic host_strobe, host_data_sel, host_read, host_rvalid, busy_flag, reset_pending, to_flag;
logic [7:0] host_wdata, host_rdata, column_pointer, vendor_config_byte, rq;
logic [4:0] row_bank_pointer;
logic [2:0] coarse_gain, pump_setting, display_control_bits;
logic [5:0] fine_trim, scroll_offset;
logic [3:0] address_control_bits, panel_map_bits;
logic [1:0] bias_ratio_select, temp_coeff_select, multiplex_select, operating_state;
logic [1:0] bias_ratio_pins = 2'h2;
logic [1:0] temp_coeff_pins = 2'h1;
logic [1:0] multiplex_pins = 2'h3;
int fail_count = 0;
int samples_checked = 0;
int n;
always #2 mclk = ~mclk;
lcd_command_decoder #(.RESET_CYCLES(20)) i_lcd_command_decoder (.mclk, .srst, .host_strobe,
    .host_data_sel, .host_read, .host_wdata, .bias_ratio_pins, .temp_coeff_pins,
    .multiplex_pins, .host_rdata, .host_rvalid, .row_bank_pointer, .column_pointer,
    .coarse_gain, .fine_trim, .pump_setting, .scroll_offset, .display_control_bits,
    .address_control_bits, .panel_map_bits, .vendor_config_byte, .bias_ratio_select,
    .temp_coeff_select, .multiplex_select, .operating_state, .busy_flag, .reset_pending);
lcd_host_bfm i_lcd_host_bfm (.mclk, .host_rdata, .host_rvalid, .reset_pending, .host_strobe,
    .host_data_sel, .host_read, .host_wdata, .timed_out(to_flag));
// ----------------------------------------
// helpers
// ----------------------------------------
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
        fail_count++;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
endtask
task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
always @(posedge to_flag)
begin
    fail_count++;
    close_out;
end
// writes get one more edge so the register update has landed
task automatic go(input logic ds, input logic r, input logic [7:0] b, input logic rude);
    i_lcd_host_bfm.xfer(ds, r, b, rude, rq);
    if (!r)
    begin
        @(posedge mclk);
        #1;
    end
endtask
task automatic cm(input logic [7:0] b);
    go(1'h0, 1'h0, b, 1'h0);
endtask
task automatic col(input logic [7:0] c);
    cm({4'h0, c[3:0]});
    cm({4'h1, c[7:4]});
endtask
task automatic await(input logic v);
    n = 0;
    while (reset_pending !== v && n < 40)
    begin
        @(posedge mclk);
        #1;
        n++;
    end
    if (n == 40)
    begin
        fail_count++;
        close_out;
    end
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_reset;
    chk(coarse_gain, 8'h03);
    chk(pump_setting, 8'h07);
    chk(vendor_config_byte, 8'h6c);
    chk(display_control_bits, 8'h00);
    chk(panel_map_bits, 8'h00);
    chk(column_pointer, 8'h00);
    chk(bias_ratio_select, 8'h02);
    chk(temp_coeff_select, 8'h01);
    chk(multiplex_select, 8'h03);
    chk(fine_trim, 8'h10);
    $display("reset values done");
endtask
task automatic t_cmds;
    cm(8'h25);
    chk(coarse_gain, 8'h05);
    cm(8'h2a);
    chk(pump_setting, 8'h02);
    cm(8'h7f);
    chk(scroll_offset, 8'h3f);
    cm(8'ha5);
    cm(8'ha7);
    cm(8'haf);
    chk(display_control_bits, 8'h07);
    cm(8'hc4);
    go(1'h0, 1'h1, 8'h00, 1'h0);
    chk(rq, 8'h60);
    chk(operating_state, 8'h03);
    cm(8'hae);
    go(1'h0, 1'h1, 8'h00, 1'h0);
    chk(rq, 8'h40);
    chk(operating_state, 8'h02);
    cm(8'he9);
    chk(bias_ratio_select, 8'h01);
    cm(8'hc9);
    chk(panel_map_bits, 8'h09);
    cm(8'ha0);
    chk(panel_map_bits, 8'h01);
    col(8'h83);
    chk(column_pointer, 8'h83);
    cm(8'hb3);
    chk(row_bank_pointer, 8'h03);
    $display("commands done");
endtask
task automatic t_data;
    cm(8'hc0);
    cm(8'h88);
    cm(8'hb2);
    col(8'h82);
    go(1'h1, 1'h0, 8'ha1, 1'h0);
    chk(column_pointer, 8'h83);
    go(1'h1, 1'h0, 8'hb2, 1'h0);
    chk(column_pointer, 8'h83);
    col(8'h82);
    go(1'h1, 1'h1, 8'h00, 1'h0);
    chk(rq, 8'ha1);
    go(1'h1, 1'h1, 8'h00, 1'h0);
    chk(rq, 8'hb2);
    chk(column_pointer, 8'h83);
    $display("data access done");
endtask
task automatic t_wrap;
    cm(8'h89);
    cm(8'hb0);
    col(8'h83);
    go(1'h1, 1'h0, 8'h11, 1'h0);
    chk(column_pointer, 8'h00);
    chk(row_bank_pointer, 8'h01);
    cm(8'h8d);
    cm(8'hb0);
    col(8'h83);
    go(1'h1, 1'h0, 8'h22, 1'h0);
    chk(row_bank_pointer, 8'h1f);
    cm(8'h89);
    col(8'h83);
    go(1'h1, 1'h0, 8'h33, 1'h0);
    chk(row_bank_pointer, 8'h00);
    $display("wrap done");
endtask
task automatic t_cursor;
    col(8'h0a);
    cm(8'hef);
    chk(address_control_bits, 8'h09);
    go(1'h1, 1'h0, 8'h44, 1'h0);
    chk(column_pointer, 8'h0b);
    go(1'h1, 1'h1, 8'h00, 1'h0);
    chk(column_pointer, 8'h0b);
    col(8'h83);
    go(1'h1, 1'h0, 8'h55, 1'h0);
    chk(column_pointer, 8'h83);
    cm(8'hee);
    chk(column_pointer, 8'h0a);
    chk(address_control_bits, 8'h01);
    $display("cursor done");
endtask
task automatic t_swrst;
    cm(8'h21);
    cm(8'h81);
    cm(8'h2b);
    chk(fine_trim, 8'h2b);
    cm(8'he2);
    await(1'b1);
    chk(busy_flag, 8'h01);
    // state code follows the timer one edge after the pending flag
    @(posedge mclk);
    #1;
    chk(operating_state, 8'h00);
    // deliberately ignores the reset-pending wait
    go(1'h0, 1'h0, 8'h26, 1'h1);
    chk(coarse_gain, 8'h03);
    await(1'b0);
    chk(n >= 10 && n <= 22, 8'h01);
    chk(fine_trim, 8'h10);
    chk(coarse_gain, 8'h03);
    go(1'h0, 1'h1, 8'h00, 1'h0);
    chk(rq, 8'h00);
    chk(operating_state, 8'h02);
    $display("software reset done");
endtask
initial
begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    t_reset;
    t_cmds;
    t_data;
    t_wrap;
    t_cursor;
    t_swrst;
    close_out;
end
endmodule // tb_top
